//--- shared/umd_pkg.sv
// constants for the modem-pin and half-duplex direction block of one channel
// assumes a 32-bit axi4-lite register bus and 8-bit control registers
package umd_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_MODEM_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FEATURE_CTRL = 8'h04;
  localparam logic [7:0] OFS_ENH_FEATURE  = 8'h08;
  localparam logic [7:0] OFS_INT_ENABLE   = 8'h0c;
  localparam logic [7:0] OFS_MODEM_STAT   = 8'h10;
  localparam logic [7:0] OFS_RX_TRIGGER   = 8'h14;

  // reset values
  localparam logic [7:0] RST_MODEM_CTRL   = 8'h00;
  localparam logic [7:0] RST_FEATURE_CTRL = 8'h00;
  localparam logic [7:0] RST_ENH_FEATURE  = 8'h00;
  localparam logic [7:0] RST_INT_ENABLE   = 8'h00;
  localparam logic [7:0] RST_RX_TRIGGER   = 8'h20;

  // modem_control_reg fields
  localparam int MCR_TERM_READY = 0;
  localparam int MCR_RTS        = 1;
  localparam int MCR_INT_EN     = 3;
  localparam int MCR_INFRARED   = 6;

  // feature_control_reg fields
  localparam int FCR_HYST_LO    = 0;
  localparam int FCR_IR_INVERT  = 2;
  localparam int FCR_DIR_CTRL   = 3;

  // enhanced_feature_reg and interrupt_enable_reg fields
  localparam int EFR_AUTO_RTS   = 6;
  localparam int EFR_AUTO_CTS   = 7;
  localparam int IER_CTS_INT    = 7;

  // status register fields
  localparam int STS_CTS        = 0;
  localparam int STS_DSR        = 1;
  localparam int STS_RING       = 2;
  localparam int STS_CARRIER    = 3;
  localparam int STS_HALF_DUP   = 4;
  localparam int STS_RTS_PIN    = 5;
  localparam int STS_TX_DIR     = 6;
  localparam int STS_CTS_DELTA  = 7;

  // hysteresis in fifo entries per field code
  localparam logic [7:0] HYST_0 = 8'h00;
  localparam logic [7:0] HYST_1 = 8'h04;
  localparam logic [7:0] HYST_2 = 8'h06;
  localparam logic [7:0] HYST_3 = 8'h08;

  // synchroniser layout: serial_in, cts, dsr, carrier, ring, half-duplex select
  localparam int          SYNC_W   = 6;
  localparam logic [5:0]  SYNC_RST = 6'h3f;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UMD_DIR_RX = 2'h1,
    UMD_DIR_TX = 2'h2
  } umd_dir_e;

endpackage

//--- design/umd_sync.sv
// two-flop synchroniser, one stage pair per bit
// assumes inputs are levels; first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module umd_sync
  import umd_pkg::*;
#(
  parameter int         W   = SYNC_W,
  parameter logic [5:0] RST = SYNC_RST
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_q[i]   <= RST[i];
          sync_out[i] <= RST[i];
        end else begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

//--- design/umd_modem_pins.sv
// modem-control pins, auto flow control and half-duplex direction for one channel
// assumes fifo levels and transmitter events come from the channel core on aclk
`timescale 1ns/100ps
`default_nettype none
module umd_modem_pins
  import umd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial and modem pins
  input  wire logic        serial_in,
  input  wire logic        clear_to_send_n,
  input  wire logic        data_set_ready_n,
  input  wire logic        carrier_detect_n,
  input  wire logic        bell_alert_in_n,
  input  wire logic        half_duplex_select_n,
  output var  logic        request_to_send_n,
  output var  logic        terminal_ready_n,
  output var  logic        aux_out_two_n,
  output var  logic        interrupt_out_a_o,
  output var  logic        interrupt_out_a_oe,
  // channel core side
  output var  logic        rx_to_decoder,
  input  wire logic [7:0]  rx_fifo_level,
  input  wire logic        tx_byte_loaded,
  input  wire logic        tx_last_stop_out,
  output var  logic        tx_allowed,
  input  wire logic        core_int_req,
  output var  logic        cts_change_event
);

  // registers
  logic [7:0] mcr_q, fcr_q, efr_q, ier_q, trig_q;
  logic       cts_delta_q;
  logic       rx_halted_q;
  umd_dir_e   dir_q, dir_d;

  // synchronised pins, all idle high except serial_in in infrared mode
  logic [SYNC_W-1:0] pins_s;
  umd_sync #(
    .W   (SYNC_W),
    .RST (SYNC_RST)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({half_duplex_select_n, bell_alert_in_n, carrier_detect_n,
                data_set_ready_n, clear_to_send_n, serial_in}),
    .sync_out (pins_s)
  );

  wire rx_s    = pins_s[0];
  wire cts_n_s = pins_s[1];
  wire dsr_n_s = pins_s[2];
  wire cd_n_s  = pins_s[3];
  wire ri_n_s  = pins_s[4];
  wire hd_n_s  = pins_s[5];

  logic cts_n_prev_q;

  // bus handshake state
  logic       aw_full_q, w_full_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic       w_lane0_q;

  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire aw_full  = aw_full_q || aw_take;
  wire w_full   = w_full_q || w_take;
  wire [7:0] wr_addr = aw_full_q ? aw_addr_q : s_axi_awaddr;
  wire [7:0] wr_data = w_full_q ? w_data_q : s_axi_wdata[7:0];
  wire       wr_lane = w_full_q ? w_lane0_q : s_axi_wstrb[0];
  wire       wr_fire = aw_full && w_full && !s_axi_bvalid;
  wire       b_done  = s_axi_bvalid && s_axi_bready;

  // write decode; only byte lane 0 holds register bits
  wire wr_mcr  = wr_fire && wr_lane && (wr_addr == OFS_MODEM_CTRL);
  wire wr_fcr  = wr_fire && wr_lane && (wr_addr == OFS_FEATURE_CTRL);
  wire wr_efr  = wr_fire && wr_lane && (wr_addr == OFS_ENH_FEATURE);
  wire wr_ier  = wr_fire && wr_lane && (wr_addr == OFS_INT_ENABLE);
  wire wr_sts  = wr_fire && wr_lane && (wr_addr == OFS_MODEM_STAT);
  wire wr_trig = wr_fire && wr_lane && (wr_addr == OFS_RX_TRIGGER);
  wire wr_hit  = (wr_addr == OFS_MODEM_CTRL) || (wr_addr == OFS_FEATURE_CTRL) ||
                 (wr_addr == OFS_ENH_FEATURE) || (wr_addr == OFS_INT_ENABLE) ||
                 (wr_addr == OFS_MODEM_STAT) || (wr_addr == OFS_RX_TRIGGER);

  // direction control
  wire dir_mode = !hd_n_s || fcr_q[FCR_DIR_CTRL];

  always_comb begin
    dir_d = dir_q;
    unique case (dir_q)
      UMD_DIR_RX: begin
        if (tx_byte_loaded)
          dir_d = UMD_DIR_TX;
      end
      UMD_DIR_TX: begin
        // a load in the same cycle keeps the line turned to transmit
        if (tx_last_stop_out && !tx_byte_loaded)
          dir_d = UMD_DIR_RX;
      end
      default: dir_d = UMD_DIR_RX;
    endcase
  end

  // receive flow control with hysteresis
  logic [7:0] hyst;
  always_comb begin
    unique case (fcr_q[FCR_HYST_LO +: 2])
      2'h0: hyst = HYST_0;
      2'h1: hyst = HYST_1;
      2'h2: hyst = HYST_2;
      2'h3: hyst = HYST_3;
    endcase
  end

  wire [8:0] halt_lvl   = {1'b0, trig_q} + {1'b0, hyst};
  wire [8:0] resume_lvl = {1'b0, trig_q} - {1'b0, hyst};
  wire       lvl_high   = {1'b0, rx_fifo_level} >= halt_lvl;
  wire       lvl_low    = resume_lvl[8] ? 1'b0 : ({1'b0, rx_fifo_level} < resume_lvl);
  wire       auto_rts   = efr_q[EFR_AUTO_RTS] && mcr_q[MCR_RTS];
  wire       rx_halted_d = !auto_rts ? 1'b0 :
                           lvl_high ? 1'b1 :
                           lvl_low ? 1'b0 : rx_halted_q;

  // pin values; direction mode overrides the software and flow-control roles
  wire rts_n_d = dir_mode ? (dir_q != UMD_DIR_TX) :
                 !(mcr_q[MCR_RTS] && !rx_halted_q);

  wire cts_edge = cts_n_s != cts_n_prev_q;
  wire cts_evt  = cts_edge && ier_q[IER_CTS_INT];

  // status input-pin bits are read from synced pins; nothing else uses dsr, carrier, ring
  wire [7:0] sts = {cts_delta_q, dir_q == UMD_DIR_TX, request_to_send_n, !hd_n_s,
                    !cd_n_s, !ri_n_s, !dsr_n_s, !cts_n_s};

  // read decode
  logic [7:0] rd_val;
  logic       rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      OFS_MODEM_CTRL:   rd_val = mcr_q;
      OFS_FEATURE_CTRL: rd_val = fcr_q;
      OFS_ENH_FEATURE:  rd_val = efr_q;
      OFS_INT_ENABLE:   rd_val = ier_q;
      OFS_MODEM_STAT:   rd_val = sts;
      OFS_RX_TRIGGER:   rd_val = trig_q;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end
  wire ar_take = s_axi_arvalid && s_axi_arready;

  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 8'h00;
      w_lane0_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_full_q     <= aw_full && !wr_fire;
      w_full_q      <= w_full && !wr_fire;
      if (aw_take)
        aw_addr_q <= s_axi_awaddr;
      if (w_take) begin
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      s_axi_awready <= !(aw_full && !wr_fire) && !s_axi_awready;
      s_axi_wready  <= !(w_full && !wr_fire) && !s_axi_wready;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_val};
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcr_q  <= RST_MODEM_CTRL;
      fcr_q  <= RST_FEATURE_CTRL;
      efr_q  <= RST_ENH_FEATURE;
      ier_q  <= RST_INT_ENABLE;
      trig_q <= RST_RX_TRIGGER;
    end else begin
      if (wr_mcr)
        mcr_q <= wr_data;
      if (wr_fcr)
        fcr_q <= wr_data;
      if (wr_efr)
        efr_q <= wr_data;
      if (wr_ier)
        ier_q <= wr_data;
      if (wr_trig)
        trig_q <= wr_data;
    end
  end

  // block state; a cts change in the clearing cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q        <= UMD_DIR_RX;
      rx_halted_q  <= 1'b0;
      cts_n_prev_q <= 1'b1;
      cts_delta_q  <= 1'b0;
    end else begin
      dir_q        <= dir_d;
      rx_halted_q  <= rx_halted_d;
      cts_n_prev_q <= cts_n_s;
      if (cts_edge)
        cts_delta_q <= 1'b1;
      else if (wr_sts && wr_data[STS_CTS_DELTA])
        cts_delta_q <= 1'b0;
    end
  end

  // pins, all from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      request_to_send_n  <= 1'b1;
      terminal_ready_n   <= 1'b1;
      aux_out_two_n      <= 1'b1;
      interrupt_out_a_o  <= 1'b0;
      interrupt_out_a_oe <= 1'b0;
      rx_to_decoder      <= 1'b1;
      tx_allowed         <= 1'b0;
      cts_change_event   <= 1'b0;
    end else begin
      request_to_send_n  <= rts_n_d;
      terminal_ready_n   <= !mcr_q[MCR_TERM_READY];
      // aux output is tied to interrupt enable, so it is no free output
      aux_out_two_n      <= !mcr_q[MCR_INT_EN];
      interrupt_out_a_o  <= core_int_req;
      interrupt_out_a_oe <= mcr_q[MCR_INT_EN];
      // infrared line idles low; inversion only in infrared mode
      rx_to_decoder      <= rx_s ^ (mcr_q[MCR_INFRARED] && fcr_q[FCR_IR_INVERT]);
      tx_allowed         <= !(efr_q[EFR_AUTO_CTS] && cts_n_s);
      cts_change_event   <= cts_evt;
    end
  end

endmodule
`default_nettype wire

//--- dv/umd_monitor.sv
// port assertions for the modem-pin block
// assumes bind onto umd_modem_pins, one clock, synchronous low reset
`timescale 1ns/100ps
`default_nettype none
module umd_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic clear_to_send_n,
  input wire logic half_duplex_select_n,
  input wire logic request_to_send_n,
  input wire logic terminal_ready_n,
  input wire logic aux_out_two_n,
  input wire logic interrupt_out_a_o,
  input wire logic interrupt_out_a_oe,
  input wire logic tx_byte_loaded,
  input wire logic tx_last_stop_out,
  input wire logic tx_allowed,
  input wire logic core_int_req,
  input wire logic cts_change_event
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // select pin settled through the synchroniser
  sequence s_dir_held;
    !half_duplex_select_n [*4];
  endsequence
  sequence s_cts_low;
    !clear_to_send_n [*4];
  endsequence
  a_aux_int_pair: assert property (aux_out_two_n == !interrupt_out_a_oe)
    else $error("aux output and interrupt enable disagree");
  a_int_follow: assert property ($past(aresetn) |-> interrupt_out_a_o == $past(core_int_req))
    else $error("interrupt output does not follow request");
  a_reset_idle: assert property (disable iff (1'b0)
    !aresetn |=> request_to_send_n && terminal_ready_n && aux_out_two_n)
    else $error("outputs not idle in reset");
  a_dir_tx: assert property (s_dir_held ##0 tx_byte_loaded |-> ##2 !request_to_send_n)
    else $error("rts not low after load");
  a_dir_rx: assert property (s_dir_held ##0 (tx_last_stop_out && !tx_byte_loaded)
    |-> ##2 request_to_send_n)
    else $error("rts not high after last stop");
  a_dtr_soft: assert property ($changed(terminal_ready_n)
    |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("dtr moved without a write");
  a_aux_soft: assert property ($changed(aux_out_two_n)
    |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("aux moved without a write");
  a_cts_event: assert property (cts_change_event
    |-> $past(clear_to_send_n, 3) != $past(clear_to_send_n, 4))
    else $error("cts event without cts change");
  a_cts_allow: assert property (s_cts_low |-> tx_allowed)
    else $error("transmit blocked with cts active");
endmodule
bind umd_modem_pins umd_monitor umd_monitor_i (.aclk, .aresetn, .s_axi_bvalid, .clear_to_send_n,
  .half_duplex_select_n, .request_to_send_n, .terminal_ready_n, .aux_out_two_n, .interrupt_out_a_o,
  .interrupt_out_a_oe, .tx_byte_loaded, .tx_last_stop_out, .tx_allowed, .core_int_req, .cts_change_event);
`default_nettype wire

//--- dv/umd_far_end.sv
// far-end model: modem or peripheral driving the receive and status lines
// assumes the bench sets mode and line levels; levels are static between frames
`timescale 1ns/100ps
`default_nettype none
module umd_far_end (
  input  wire logic       ir_mode,
  input  wire logic [3:0] stat_n,
  input  wire logic       dir_n,
  output wire logic       serial_in,
  output wire logic       clear_to_send_n,
  output wire logic       data_set_ready_n,
  output wire logic       carrier_detect_n,
  output wire logic       bell_alert_in_n,
  output wire logic       half_duplex_select_n
);
  // no characters sent: line rests at its idle level
  assign serial_in            = !ir_mode;
  assign clear_to_send_n      = stat_n[0];
  assign data_set_ready_n     = stat_n[1];
  assign carrier_detect_n     = stat_n[2];
  assign bell_alert_in_n      = stat_n[3];
  assign half_duplex_select_n = dir_n;
  // aux output left unconnected: it tracks interrupt enable
endmodule
`default_nettype wire

//--- dv/tb_uart_modem_pins_and_duplex_dir.sv
// self-checking bench for the modem-pin block
// assumes the far-end model and the bound monitor beside the design
`timescale 1ns/100ps
`default_nettype none
module tb_uart_modem_pins_and_duplex_dir import umd_pkg::*;;
  logic        aclk = 0, aresetn = 0, ir_mode = 0, dir_n = 1;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rx_fifo_level = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'h1, stat_n = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        tx_byte_loaded = 0, tx_last_stop_out = 0, core_int_req = 0;
  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic        serial_in, clear_to_send_n, data_set_ready_n, carrier_detect_n, bell_alert_in_n;
  wire logic        half_duplex_select_n, request_to_send_n, terminal_ready_n, aux_out_two_n;
  wire logic        interrupt_out_a_o, interrupt_out_a_oe, rx_to_decoder, tx_allowed, cts_change_event;
  int          err_count = 0, compares = 0;
  umd_modem_pins umd_modem_pins_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_in, .clear_to_send_n, .data_set_ready_n, .carrier_detect_n, .bell_alert_in_n,
    .half_duplex_select_n, .request_to_send_n, .terminal_ready_n, .aux_out_two_n, .interrupt_out_a_o,
    .interrupt_out_a_oe, .rx_to_decoder, .rx_fifo_level, .tx_byte_loaded, .tx_last_stop_out, .tx_allowed,
    .core_int_req, .cts_change_event);
  umd_far_end umd_far_end_i (.ir_mode, .stat_n, .dir_n, .serial_in, .clear_to_send_n, .data_set_ready_n,
    .carrier_detect_n, .bell_alert_in_n, .half_duplex_select_n);
  always #2.5 aclk = ~aclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 0;
    cyc(2);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    chk("rdata", {24'h0, e}, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    s_axi_rready <= 0;
  endtask
  task automatic ev(input logic ld, input logic st, input logic e);
    @(posedge aclk);
    tx_byte_loaded <= ld;
    tx_last_stop_out <= st;
    @(posedge aclk);
    tx_byte_loaded <= 0;
    tx_last_stop_out <= 0;
    cyc(3);
    chk("rts dir", e, request_to_send_n);
  endtask
  task automatic t_reset;
    @(posedge aclk);
    aresetn <= 0;
    cyc(4);
    chk("rts rst", 1, request_to_send_n);
    chk("dtr rst", 1, terminal_ready_n);
    chk("aux rst", 1, aux_out_two_n);
    chk("oe rst", 0, interrupt_out_a_oe);
    @(posedge aclk);
    aresetn <= 1;
    cyc(2);
    rdc(OFS_MODEM_CTRL, RST_MODEM_CTRL, RESP_OKAY);
    rdc(OFS_FEATURE_CTRL, RST_FEATURE_CTRL, RESP_OKAY);
    rdc(8'h18, 8'h00, RESP_SLVERR);
    rdc(OFS_RX_TRIGGER, RST_RX_TRIGGER, RESP_OKAY);
    wr(8'h18, 8'hff, RESP_SLVERR);
  endtask
  task automatic t_pins;
    wr(OFS_MODEM_CTRL, 8'h09);
    @(posedge aclk) core_int_req <= 1;
    cyc(2);
    chk("dtr", 0, terminal_ready_n);
    chk("aux", 0, aux_out_two_n);
    chk("oe", 1, interrupt_out_a_oe);
    chk("int", 1, interrupt_out_a_o);
    wr(OFS_MODEM_CTRL, 8'h00);
    chk("dtr", 1, terminal_ready_n);
    chk("aux", 1, aux_out_two_n);
    chk("oe", 0, interrupt_out_a_oe);
    chk("rts", 1, request_to_send_n);
    // byte lane 0 off: the write is answered but must not land
    @(posedge aclk) s_axi_wstrb <= 4'h0;
    wr(OFS_MODEM_CTRL, 8'h01);
    rdc(OFS_MODEM_CTRL, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
  endtask
  task automatic t_ir;
    chk("rx idle", 1, rx_to_decoder);
    wr(OFS_FEATURE_CTRL, 8'h04);
    @(posedge aclk) ir_mode <= 1;
    cyc(4);
    chk("rx ir off", 0, rx_to_decoder);
    wr(OFS_MODEM_CTRL, 8'h40);
    chk("rx ir inv", 1, rx_to_decoder);
    wr(OFS_FEATURE_CTRL, 8'h00);
    chk("rx ir", 0, rx_to_decoder);
    wr(OFS_MODEM_CTRL, 8'h00);
    @(posedge aclk) ir_mode <= 0;
  endtask
  task automatic t_rts;
    logic [95:0] lv = 96'h17192827_191b2625_1b1e2422;
    logic [3:0]  ex = 4'b0110;
    wr(OFS_MODEM_CTRL, 8'h02);
    chk("rts sw", 0, request_to_send_n);
    wr(OFS_MODEM_CTRL, 8'h00);
    wr(OFS_ENH_FEATURE, 8'h40);
    @(posedge aclk) rx_fifo_level <= 8'h30;
    cyc(3);
    chk("rts auto off", 1, request_to_send_n);
    wr(OFS_MODEM_CTRL, 8'h02);
    chk("rts auto hi", 1, request_to_send_n);
    @(posedge aclk) rx_fifo_level <= 8'h10;
    cyc(3);
    chk("rts auto lo", 0, request_to_send_n);
    // hysteresis codes 1 to 3: trigger 0x20 plus or minus 4, 6 and 8 entries
    for (int h = 0; h < 3; h++) begin
      wr(OFS_FEATURE_CTRL, 8'(h + 1));
      for (int i = 0; i < 4; i++) begin
        @(posedge aclk) rx_fifo_level <= lv[h*32+i*8+:8];
        cyc(3);
        chk("rts hyst", ex[i], request_to_send_n);
      end
    end
    wr(OFS_ENH_FEATURE, 8'h00);
    wr(OFS_FEATURE_CTRL, 8'h00);
    wr(OFS_MODEM_CTRL, 8'h00);
  endtask
  task automatic t_cts;
    logic [31:0] n;
    wr(OFS_ENH_FEATURE, 8'h80);
    chk("cts gate", 0, tx_allowed);
    wr(OFS_INT_ENABLE, 8'h80);
    for (int v = 0; v < 2; v++) begin
      @(posedge aclk) stat_n[0] <= v[0];
      n = 0;
      repeat (6) begin
        cyc(1);
        n += cts_change_event;
      end
      chk("cts event", 1, n);
      chk("cts gate", !v[0], tx_allowed);
    end
  endtask
  task automatic t_inert;
    wr(OFS_MODEM_STAT, 8'h80);
    wr(OFS_MODEM_CTRL, 8'h02);
    @(posedge aclk) stat_n <= 4'h1;
    cyc(4);
    chk("gate inert", 0, tx_allowed);
    chk("rts inert", 0, request_to_send_n);
    rdc(OFS_MODEM_STAT, 8'h0e, RESP_OKAY);
    stat_n <= 4'hf;
    wr(OFS_ENH_FEATURE, 8'h00);
    wr(OFS_MODEM_CTRL, 8'h00);
  endtask
  task automatic t_dir;
    ev(1, 0, 1);
    wr(OFS_FEATURE_CTRL, 8'h08);
    ev(1, 0, 0);
    ev(0, 1, 1);
    wr(OFS_MODEM_CTRL, 8'h02);
    chk("rts dir rx", 1, request_to_send_n);
    wr(OFS_FEATURE_CTRL, 8'h00);
    chk("rts normal", 0, request_to_send_n);
    wr(OFS_MODEM_CTRL, 8'h00);
    @(posedge aclk) dir_n <= 0;
    cyc(5);
    ev(1, 0, 0);
    ev(0, 1, 1);
    @(posedge aclk) dir_n <= 1;
  endtask
  task automatic give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // whole sequence is a few hundred cycles; this leaves wide margin
  initial begin
    #100us;
    err_count++;
    give_verdict();
  end
  initial begin
    t_reset();
    t_pins();
    t_ir();
    t_rts();
    t_cts();
    t_inert();
    t_dir();
    wr(OFS_MODEM_CTRL, 8'h0b);
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
